// File: ioc_defs.svh
// Register offsets, field positions and reset values of the I/O cell
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define IOC_ADDR_W 12
`define IOC_CFG_ADDR 12'h000
`define IOC_STAT_ADDR 12'h004

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define IOC_CFG_RESET 32'h0000_0000
`define IOC_F_PATH_A_REG 0
`define IOC_F_PATH_B_REG 1
`define IOC_F_CE_IN_EN 2
`define IOC_F_CE_OUT_EN 3
`define IOC_F_CE_USED 4
`define IOC_F_IN_INIT_SET 5
`define IOC_F_OUT_INIT_SET 6
`define IOC_F_IN_LATCH 7
`define IOC_F_LAG_LO 8
`define IOC_F_LAG_HI 9
`define IOC_F_EXT_VARIANT 10
`define IOC_F_CAPTURE_EN 11
`define IOC_F_IN_CLK_INV 12
`define IOC_F_OUT_CLK_INV 13
`define IOC_F_OUT_INV 14
`define IOC_F_TRI_INV 15
`define IOC_F_OUT_REG_SEL 16
`define IOC_F_TRI_USED 17
`define IOC_F_CFG_DONE 31
`define IOC_CFG_WMASK 32'h8003_FFFF

// ----------------------------------------
// Input lag taps (hclk cycles)
// ----------------------------------------
`define IOC_FULL_TAPS 4
`define IOC_MED_TAPS 2

`endif

// File: ioc_pkg.sv
// Types shared by the I/O cell design
package ioc_pkg;

	// Input lag selection as written in the configuration field
	typedef enum logic [1:0] {
		ioc_lag_default,
		ioc_lag_medium,
		ioc_lag_bypass,
		ioc_lag_spare
	} ioc_lag_t;

	// Effective lag actually applied to the pad data
	typedef enum logic [1:0] {
		ioc_eff_full,
		ioc_eff_medium,
		ioc_eff_none
	} ioc_eff_lag_t;

endpackage

// File: ioc_cell.sv
// Storage and path logic of one programmable I/O cell with AHB-Lite registers
`timescale 1ns/1ns
`include "ioc_defs.svh"

// Overview of operation
// RL1 - Core outputs choose direct or stored input
// RL2 - Shared enable, applied to chosen elements
// RL3 - Enable acts like logic-cell enable, uninverted
// RL4 - Init sets configured level, reset default
// RL5 - Flop loads on edge, latch passes low
// RL6 - Unconnected clock enable counts as high
// RL7 - Optional input lag, full by default
// RL8 - Basic variant: full lag or bypass
// RL9 - Extended variant: full, medium, or none
// RL10 - Early latch clocked by output clock
// RL11 - Early latch transparent low, then flop
// RL12 - Early latch may feed high latch
// RL13 - Capture clocks invertible inside the cell
// RL14 - Early latch makes medium the default
// RL15 - Output optionally inverted, direct or registered
// RL16 - High three-state control floats the driver
// RL17 - Data and three-state polarity independent
// RL18 - Output flop edge load; float on one
// RL19 - Unconnected three-state control counts as low
// RL20 - Configuration frozen once marked complete
module ioc_cell (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	input wire logic in_clk,
	input wire logic out_clk,
	input wire logic logic_cell_clk_gate,
	input wire logic global_init_pulse,
	input wire logic core_out_data,
	input wire logic core_tri,
	output logic core_input_path_a,
	output logic core_input_path_b
);

	// ----------------------------------------
	// Lag decoding
	// ----------------------------------------
	function automatic ioc_pkg::ioc_eff_lag_t eff_lag(
		input logic [1:0] sel,
		input logic ext,
		input logic cap
	);
		ioc_pkg::ioc_eff_lag_t r;
		r = ioc_pkg::ioc_eff_full;
		if (sel == ioc_pkg::ioc_lag_bypass) begin
			r = ioc_pkg::ioc_eff_none; // RL8
		end else if (ext) begin
			if (sel == ioc_pkg::ioc_lag_medium) begin
				r = ioc_pkg::ioc_eff_medium; // RL9
			end else if (cap) begin
				r = ioc_pkg::ioc_eff_medium; // RL14
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Bus state
	// ----------------------------------------
	logic [31:0] cfg;
	logic [31:0] next_cfg;
	logic wr_pend;
	logic next_wr_pend;
	logic [`IOC_ADDR_W-1:0] wr_addr;
	logic [`IOC_ADDR_W-1:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic addr_ok;

	// ----------------------------------------
	// Cell state
	// ----------------------------------------
	logic [`IOC_FULL_TAPS-1:0] lag_line;
	logic [`IOC_FULL_TAPS-1:0] next_lag_line;
	logic in_clk_prev;
	logic next_in_clk_prev;
	logic out_clk_prev;
	logic next_out_clk_prev;
	logic cap_q;
	logic next_cap_q;
	logic in_q;
	logic next_in_q;
	logic out_q;
	logic next_out_q;
	logic next_pad_out;
	logic next_pad_oe;
	logic next_path_a;
	logic next_path_b;

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	logic path_a_reg;
	logic path_b_reg;
	logic ce_in_en;
	logic ce_out_en;
	logic ce_used;
	logic in_init_set;
	logic out_init_set;
	logic in_latch;
	logic [1:0] lag_sel;
	logic ext_variant;
	logic capture_en;
	logic in_clk_inv;
	logic out_clk_inv;
	logic out_inv;
	logic tri_inv;
	logic out_reg_sel;
	logic tri_used;
	logic cfg_done;

	assign path_a_reg = cfg[`IOC_F_PATH_A_REG];
	assign path_b_reg = cfg[`IOC_F_PATH_B_REG];
	assign ce_in_en = cfg[`IOC_F_CE_IN_EN];
	assign ce_out_en = cfg[`IOC_F_CE_OUT_EN];
	assign ce_used = cfg[`IOC_F_CE_USED];
	assign in_init_set = cfg[`IOC_F_IN_INIT_SET];
	assign out_init_set = cfg[`IOC_F_OUT_INIT_SET];
	assign in_latch = cfg[`IOC_F_IN_LATCH];
	assign lag_sel = cfg[`IOC_F_LAG_HI:`IOC_F_LAG_LO];
	assign ext_variant = cfg[`IOC_F_EXT_VARIANT];
	assign capture_en = cfg[`IOC_F_CAPTURE_EN];
	assign in_clk_inv = cfg[`IOC_F_IN_CLK_INV];
	assign out_clk_inv = cfg[`IOC_F_OUT_CLK_INV];
	assign out_inv = cfg[`IOC_F_OUT_INV];
	assign tri_inv = cfg[`IOC_F_TRI_INV];
	assign out_reg_sel = cfg[`IOC_F_OUT_REG_SEL];
	assign tri_used = cfg[`IOC_F_TRI_USED];
	assign cfg_done = cfg[`IOC_F_CFG_DONE];

	// ----------------------------------------
	// Derived cell signals
	// ----------------------------------------
	logic in_clk_eff;
	logic out_clk_eff;
	logic in_rise;
	logic out_rise;
	logic ce_val;
	logic ce_in;
	logic ce_out;
	logic cap_active;
	logic lagged;
	logic store_src;
	logic in_open;
	logic out_data;
	logic tri_val;
	ioc_pkg::ioc_eff_lag_t lag_now;

	// Early latch exists only in the extended variant
	assign cap_active = capture_en & ext_variant; // RL10
	assign in_clk_eff = in_clk ^ in_clk_inv; // RL13
	assign out_clk_eff = out_clk ^ out_clk_inv; // RL13
	assign in_rise = in_clk_eff & ~in_clk_prev;
	assign out_rise = out_clk_eff & ~out_clk_prev;
	// No polarity control on the shared enable
	assign ce_val = ce_used ? logic_cell_clk_gate : 1'b1; // RL3 RL6
	assign ce_in = ce_in_en ? ce_val : 1'b1; // RL2
	assign ce_out = ce_out_en ? ce_val : 1'b1; // RL2
	assign lag_now = eff_lag(lag_sel, ext_variant, cap_active);
	assign store_src = cap_active ? cap_q : lagged;
	// Behind the early latch the input latch opens on high
	assign in_open = cap_active ? in_clk_eff : ~in_clk_eff; // RL5 RL12
	assign out_data = core_out_data ^ out_inv; // RL15 RL17
	assign tri_val = tri_used ? (core_tri ^ tri_inv) : 1'b0; // RL17 RL19

	// ----------------------------------------
	// Input lag line
	// ----------------------------------------
	// Tap zero takes the pad; each later tap is one hclk older
	assign next_lag_line[0] = pad_in;
	for (genvar t = 1; t < `IOC_FULL_TAPS; t++) begin : g_tap
		assign next_lag_line[t] = lag_line[t-1];
	end

	// Lag is counted in hclk cycles, not in delay-line nanoseconds
	always_comb begin
		unique case (lag_now)
			ioc_pkg::ioc_eff_full: lagged = lag_line[`IOC_FULL_TAPS-1]; // RL7
			ioc_pkg::ioc_eff_medium: lagged = lag_line[`IOC_MED_TAPS-1];
			ioc_pkg::ioc_eff_none: lagged = pad_in;
			default: lagged = lag_line[`IOC_FULL_TAPS-1];
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lag_line <= '0;
		end else begin
			lag_line <= next_lag_line;
		end
	end

	// ----------------------------------------
	// Clock edge tracking
	// ----------------------------------------
	always_comb begin
		next_in_clk_prev = in_clk_eff;
		next_out_clk_prev = out_clk_eff;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Seen as high, so a clock already high at release is no edge
			in_clk_prev <= 1'b1;
			out_clk_prev <= 1'b1;
		end else begin
			in_clk_prev <= next_in_clk_prev;
			out_clk_prev <= next_out_clk_prev;
		end
	end

	// ----------------------------------------
	// Input storage
	// ----------------------------------------
	// Latch modes follow on every hclk while open, so they track like a gate
	always_comb begin
		next_cap_q = cap_q;
		next_in_q = in_q;
		if (!out_clk_eff) begin
			next_cap_q = lagged; // RL11
		end
		if (global_init_pulse) begin
			next_in_q = in_init_set; // RL4
		end else if (ce_in) begin
			if (in_latch) begin
				if (in_open) begin
					next_in_q = store_src; // RL5 RL12
				end
			end else if (in_rise) begin
				next_in_q = store_src; // RL5 RL11
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_q <= 1'b0;
			in_q <= 1'b0;
		end else begin
			cap_q <= next_cap_q;
			in_q <= next_in_q;
		end
	end

	// ----------------------------------------
	// Core-side outputs
	// ----------------------------------------
	// Registered path shows the element as it stands after this edge
	always_comb begin
		next_path_a = path_a_reg ? next_in_q : pad_in; // RL1
		next_path_b = path_b_reg ? next_in_q : pad_in; // RL1
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_input_path_a <= 1'b0;
			core_input_path_b <= 1'b0;
		end else begin
			core_input_path_a <= next_path_a;
			core_input_path_b <= next_path_b;
		end
	end

	// ----------------------------------------
	// Output storage and pad drive
	// ----------------------------------------
	always_comb begin
		next_out_q = out_q;
		if (global_init_pulse) begin
			next_out_q = out_init_set; // RL4
		end else if (ce_out && out_rise) begin
			next_out_q = out_data; // RL18
		end
		next_pad_out = out_reg_sel ? next_out_q : out_data; // RL15
		// Float needs no cell clock: the driver lets go on the next hclk
		next_pad_oe = ~tri_val; // RL16 RL18
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= 1'b0;
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
		end else begin
			out_q <= next_out_q;
			pad_out <= next_pad_out;
			pad_oe <= next_pad_oe;
		end
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	logic take;
	logic [`IOC_ADDR_W-1:0] a_addr;
	logic [31:0] stat_word;

	assign take = hsel & hready & htrans[1];
	assign a_addr = haddr[`IOC_ADDR_W-1:0];
	// Only whole words in the low window decode; anything else reads as zero
	assign addr_ok = (haddr[31:`IOC_ADDR_W] == '0) && (hsize == 3'h2);

	// Status is read-only; writes to it are dropped by the decode
	always_comb begin
		stat_word = '0;
		stat_word[0] = pad_in;
		stat_word[1] = lagged;
		stat_word[2] = cap_q;
		stat_word[3] = in_q;
		stat_word[4] = out_q;
		stat_word[5] = pad_oe;
		stat_word[6] = core_input_path_a;
		stat_word[7] = core_input_path_b;
		stat_word[9:8] = lag_now;
	end

	always_comb begin
		next_wr_pend = take & hwrite & addr_ok;
		next_wr_addr = a_addr;
		next_hrdata = '0;
		if (take && !hwrite && addr_ok) begin
			unique case (a_addr)
				`IOC_CFG_ADDR: next_hrdata = cfg;
				`IOC_STAT_ADDR: next_hrdata = stat_word;
				default: next_hrdata = '0;
			endcase
		end
		next_cfg = cfg;
		// Frozen once software marks configuration complete
		if (wr_pend && wr_addr == `IOC_CFG_ADDR && !cfg_done) begin
			next_cfg = hwdata & `IOC_CFG_WMASK; // RL20
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= `IOC_CFG_RESET;
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			// Zero wait states: every transfer ends in one cycle
			cfg <= next_cfg;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

endmodule

// File: ioc_pad_model.sv
// Board side of the pad for the I/O cell bench
`timescale 1ns/1ns
module ioc_pad_model (
	input wire logic pad_out,
	input wire logic pad_oe,
	input wire logic board_val,
	output logic pad_in
);
	// Cell wins while it drives; the board drives the released pin
	assign pad_in = pad_oe ? pad_out : board_val;
endmodule

// File: ioc_cell_props.sv
// Assertion checker for the I/O cell, bound to its ports
`timescale 1ns/1ns
`include "ioc_defs.svh"
module ioc_cell_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic pad_out,
	input wire logic pad_oe,
	input wire logic out_clk,
	input wire logic logic_cell_clk_gate,
	input wire logic global_init_pulse,
	input wire logic core_out_data,
	input wire logic core_tri
);
	// ----------------------------------------
	// Shadow configuration
	// ----------------------------------------
	logic up;
	logic wp;
	logic [31:0] cfg;
	wire rd = hsel && hready && htrans[1] && !hwrite;
	wire eo = out_clk ^ cfg[13];
	wire en = logic_cell_clk_gate || !(cfg[4] && cfg[3]);
	// First edge after reset still sees reset-time history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up <= 1'h0;
			wp <= 1'h0;
			cfg <= '0;
		end else begin
			up <= 1'h1;
			wp <= hsel && hready && htrans[1] && hwrite && haddr == '0;
			if (wp && !cfg[31])
				cfg <= hwdata & `IOC_CFG_WMASK;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn || !up);
	sequence s_olo;
		!eo;
	endsequence
	sequence s_ohi;
		eo && en && cfg[16] && !global_init_pulse;
	endsequence
	AST_READY: assert property (hreadyout && !hresp)
		else $error("bus stalled or error response");
	AST_RD_CFG: assert property (rd && haddr == '0 |=> hrdata == $past(cfg))
		else $error("config read back wrong");
	AST_RD_IDLE: assert property (!rd |=> hrdata == '0)
		else $error("read data not cleared");
	AST_OE: assert property (pad_oe == !($past(cfg[17]) && ($past(core_tri) ^ $past(cfg[15]))))
		else $error("driver enable wrong");
	AST_OUT_DIRECT: assert property (!$past(cfg[16]) |-> pad_out == ($past(core_out_data) ^ $past(cfg[14])))
		else $error("direct output wrong");
	AST_OUT_INIT: assert property ($past(global_init_pulse && cfg[16]) |-> pad_out == $past(cfg[6]))
		else $error("output init level wrong");
	AST_OUT_LOAD: assert property (s_olo ##1 s_ohi |=> pad_out == $past(core_out_data ^ cfg[14]))
		else $error("output flop did not load");
	AST_OUT_HOLD: assert property (cfg[16] && $past(cfg[16]) && !global_init_pulse && !(eo && !$past(eo) && en)
		|=> $stable(pad_out))
		else $error("output flop did not hold");
endmodule
bind ioc_cell ioc_cell_props ioc_cell_props_i (.*);

// File: test_io_cell_storage_elements.sv
// Self-checking bench for the I/O cell storage and path logic
`timescale 1ns/1ns
`include "ioc_defs.svh"
module test_io_cell_storage_elements;
	logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, chk = '0;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r, rn, c = '0;
	logic hreadyout, hresp, pad_in, pad_out, pad_oe, pa, pb, lag;
	logic ic = '0, oc = '0, ce = '0, gi = '0, od = '0, ot = '0, pv = '0;
	logic iq, oq, pic, poc, cq;
	logic [7:0] h;
	logic [3:0] ea;
	logic [31:0] cf [7] = '{32'h0000_0000, 32'h0003_00ff, 32'h0003_f51f, 32'h0003_4217, 32'h0002_810b,
		32'h0003_1c03, 32'h0003_2c97};
	integer errors = 0, checks = 0, seed = 72967, i;
	always #4 hclk = ~hclk;
	ioc_cell ioc_cell_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.in_clk(ic), .out_clk(oc), .logic_cell_clk_gate(ce), .global_init_pulse(gi), .core_out_data(od),
		.core_tri(ot), .core_input_path_a(pa), .core_input_path_b(pb));
	ioc_pad_model ioc_pad_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .board_val(pv), .pad_in(pad_in));
	function automatic int lt(input logic [31:0] v);
		if (v[9:8] == 2'h2)
			return 0;
		if (v[10] && (v[9:8] == 2'h1 || v[11]))
			return `IOC_MED_TAPS;
		return `IOC_FULL_TAPS;
	endfunction
	function automatic logic [31:0] le(input logic [31:0] v);
		return lt(v) == 0 ? 32'h0000_0200 : lt(v) == `IOC_MED_TAPS ? 32'h0000_0100 : 32'h0000_0000;
	endfunction
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ----------------------------------------
	// Reference model, one step per clock
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{iq, oq, cq, h} = '0;
			pic = 1'h1;
			poc = 1'h1;
		end else begin
			if (chk)
				cmp({28'h0, pa, pb, pad_out, pad_oe}, {28'h0, ea});
			lag = lt(c) == 0 ? pad_in : h[lt(c) - 1];
			if (gi)
				iq = c[5];
			else if ((ce || !(c[4] && c[2])) && (c[7] ? (c[10] && c[11]) == (ic ^ c[12]) : (ic ^ c[12]) && !pic))
				iq = c[10] && c[11] ? cq : lag;
			if (!(oc ^ c[13]))
				cq = lag;
			if (gi)
				oq = c[6];
			else if ((ce || !(c[4] && c[3])) && (oc ^ c[13]) && !poc)
				oq = od ^ c[14];
			ea = {c[0] ? iq : pad_in, c[1] ? iq : pad_in, c[16] ? oq : od ^ c[14], !(c[17] && (ot ^ c[15]))};
			pic = ic ^ c[12];
			poc = oc ^ c[13];
			h = {h[6:0], pad_in};
		end
	end
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		r = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
		if (a == '0 && !c[31])
			c <= d & `IOC_CFG_WMASK;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		xfer(1'h0, a, '0);
		cmp(r, e);
	endtask
	// An init pulse first, so the model starts in step
	task run(input int n);
		gi <= 1'h1;
		@(posedge hclk);
		gi <= 1'h0;
		@(posedge hclk);
		chk <= 1'h1;
		repeat (n) begin
			@(posedge hclk);
			rn = $random(seed);
			{ic, oc, ce, od, ot, pv} <= rn[5:0];
			gi <= rn[9:6] == 4'h0;
		end
		chk <= 1'h0;
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		for (i = 0; i < 7; i++) begin
			wr('0, cf[i]);
			rd('0, cf[i] & `IOC_CFG_WMASK);
			run(300);
		end
		for (i = 0; i < 16; i++) begin
			wr('0, i << 8);
			xfer(1'h0, 32'h0000_0004, '0);
			cmp(r & 32'h0000_0300, le(i << 8));
		end
		wr(32'h0000_0004, '1);
		rd(32'h0000_0008, '0);
		rd('0, 32'h0000_0f00);
		wr('0, 32'h8000_0001);
		wr('0, '0);
		rd('0, 32'h8000_0001);
		hresetn <= 1'h0;
		c <= '0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rd('0, '0);
		run(100);
		print_verdict;
	end
	initial begin
		#100000;
		errors++;
		print_verdict;
	end
endmodule
